/* tpf_top.sv */
// Timer pair, timer C data buffer and interrupt flag registers behind AXI4-Lite
// Functional notes
// - Timer C has an 8-bit read/write data buffer.
// - External interrupt 3 keeps separate falling-edge and rising-edge seen flags.
// - Flags zero bit 1 watchdog timeout, bit 0 ext0; sticky until cleared.
// - Writing ext0 enable as 0 also clears the ext0 flag.
// - Flags one: wide timer bit 6, timer C bit 2, timer A bit 0.
// - Flags one: ext5 bit 7, conversion bit 5, ext3 bit 3, serial bit 1.
// - Flag 1 means request pending; unused flag positions read 0.
// - Software writes to flags one and two only clear, never set.
// - Reading flags one or two returns flags ANDed with their mask.
// - Flags two bit 6 rx error; cleared by software or serial disable.
// - Flags two: rx full bit 5, tx empty 4, time base 3, ext1 2.
// - Flags two bit 0 set on basic timer overflow, sticky until cleared.
// - Writing 1 to timer A control bit 7 captures count; 0 does nothing.
// - Timer A run bit 1 counts; 0 stops and clears the counter.
// - Timer A clock: Fc/2^12, Fc/2^10, Fc/2^7 or external pin.
// - Timer A mode 0 is timer/counter, 1 is capture mode.
// - Timer A buffers A and B are untouched by reset.
// - Wide timer mode bit 4: 0 timer/counter, 1 window mode.
// - Wide timer run bit 3: 1 counts, 0 stops and clears.
// - Wide clock: Fc/2^23, 2^13, 2^8, 2^3, Fc; 101/110 idle; 111 pin.
// - Wide timer data split into high byte and low byte registers.
// - Wide control bits 7:6 show the converter result's low two bits.
// - Timer C run 0 stops and clears; 1 counts.
`timescale 1ns/100ps
module tpf_top
    import tpf_pkg::*;
#(
    parameter int TC_DIV_EXP = 3
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext0_evt,
    input wire logic wdt_timeout_evt,
    input wire logic ext1_evt,
    input wire logic ext5_evt,
    input wire logic ext3_pin,
    input wire logic conv_done_evt,
    input wire logic serial_periph_evt,
    input wire logic serial_rx_err_evt,
    input wire logic rx_full_evt,
    input wire logic tx_empty_evt,
    input wire logic time_base_evt,
    input wire logic basic_timer_ovf_evt,
    input wire logic serial_enable,
    input wire logic [1:0] conversion_low_bits,
    input wire logic timer_a_pin,
    input wire logic wide_timer_pin
);
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic aw_have_ff, w_have_ff;
    logic [AXI_AW-1:0] aw_addr_ff;
    logic [31:0] w_data_ff, rdata_ff;
    logic [3:0] w_strb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic aw_fire, w_fire, b_fire, ar_fire, r_fire, wr_do, wr_ok;
    logic [7:0] wbyte;
    logic wr_f0, wr_f1, wr_f2, wr_ta_ctrl, wr_buf_a, wr_buf_b, wr_wt_ctrl;
    logic wr_wt_hi, wr_wt_lo, wr_m1, wr_m2, wr_aux, wr_tc;
    logic [22:0] presc_ff;
    logic [7:0] timer_c_data_ff, tc_cnt_ff, ta_cnt_ff, ta_buf_a_ff, ta_buf_b_ff;
    logic [7:0] wt_hi_ff, wt_lo_ff, mask_one_ff, mask_two_ff;
    logic [15:0] wt_cnt_ff;
    logic ta_run_ff, ta_capmode_ff, wt_mode_ff, wt_run_ff, ext0_enable_ff, timer_c_run_ff;
    logic [1:0] ta_clk_sel_ff;
    tpf_wt_clk_t wt_clk_sel_ff;
    logic ta_pin_prev_ff, wt_pin_prev_ff, ext3_prev_ff;
    logic ta_tick, wt_tick, tc_tick, ta_match, ta_ovf, wt_match, tc_match, ta_soft_cap;
    logic ext3_rise, ext3_fall;
    logic [7:0] flags_zero_ff, flags_one_ff, flags_two_ff;
    logic [7:0] set0, set1, set2, clr0, clr1, clr2;
    logic [7:0] rd_byte;
    logic rd_ok;
    // Handshakes
    assign aw_fire = s_axi_awvalid & awready_ff;
    assign w_fire = s_axi_wvalid & wready_ff;
    assign b_fire = bvalid_ff & s_axi_bready;
    assign ar_fire = s_axi_arvalid & arready_ff;
    assign r_fire = rvalid_ff & s_axi_rready;
    assign wr_do = aw_have_ff & w_have_ff & ~bvalid_ff;
    // Write address and data capture, either order
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
        end else begin
            if (aw_fire) begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end else if (wr_do) begin
                aw_have_ff <= 1'b0;
            end
            if (w_fire) begin
                w_have_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end else if (wr_do) begin
                w_have_ff <= 1'b0;
            end
        end
    end
    // Write channel readiness and response
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            if (aw_fire) awready_ff <= 1'b0;
            else if (b_fire) awready_ff <= 1'b1;
            if (w_fire) wready_ff <= 1'b0;
            else if (b_fire) wready_ff <= 1'b1;
            if (wr_do) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (b_fire) begin
                bvalid_ff <= 1'b0;
            end
        end
    end
    // Address decode for writes; only byte lane 0 holds register bits
    assign wbyte = w_data_ff[7:0];
    always_comb begin
        wr_ok = 1'b1;
        {wr_f0, wr_f1, wr_f2, wr_ta_ctrl, wr_buf_a, wr_buf_b, wr_wt_ctrl} = 7'h00;
        {wr_wt_hi, wr_wt_lo, wr_m1, wr_m2, wr_aux, wr_tc} = 6'h00;
        case (aw_addr_ff)
            OFS_TIMER_C_DATA: wr_tc = wr_do & w_strb_ff[0];
            OFS_FLAGS_ZERO: wr_f0 = wr_do & w_strb_ff[0];
            OFS_FLAGS_ONE: wr_f1 = wr_do & w_strb_ff[0];
            OFS_FLAGS_TWO: wr_f2 = wr_do & w_strb_ff[0];
            OFS_TA_CTRL: wr_ta_ctrl = wr_do & w_strb_ff[0];
            OFS_TA_BUF_A: wr_buf_a = wr_do & w_strb_ff[0];
            OFS_TA_BUF_B: wr_buf_b = wr_do & w_strb_ff[0];
            OFS_WT_CTRL: wr_wt_ctrl = wr_do & w_strb_ff[0];
            OFS_WT_HIGH: wr_wt_hi = wr_do & w_strb_ff[0];
            OFS_WT_LOW: wr_wt_lo = wr_do & w_strb_ff[0];
            OFS_MASK_ONE: wr_m1 = wr_do & w_strb_ff[0];
            OFS_MASK_TWO: wr_m2 = wr_do & w_strb_ff[0];
            OFS_AUX_CTRL: wr_aux = wr_do & w_strb_ff[0];
            default: wr_ok = 1'b0;
        endcase
    end
    // Control registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timer_c_data_ff <= RST_BYTE;
            ta_run_ff <= 1'b0;
            ta_clk_sel_ff <= 2'h0;
            ta_capmode_ff <= 1'b0;
            wt_mode_ff <= 1'b0;
            wt_run_ff <= 1'b0;
            wt_clk_sel_ff <= WT_CK_DIV23;
            wt_hi_ff <= RST_BYTE;
            wt_lo_ff <= RST_BYTE;
            mask_one_ff <= RST_BYTE;
            mask_two_ff <= RST_BYTE;
            ext0_enable_ff <= 1'b0;
            timer_c_run_ff <= 1'b0;
        end else begin
            if (wr_tc) timer_c_data_ff <= wbyte;
            if (wr_ta_ctrl) begin
                ta_run_ff <= wbyte[TA_RUN_BIT];
                ta_clk_sel_ff <= wbyte[TA_CK_LSB+:2];
                ta_capmode_ff <= wbyte[TA_MODE_BIT];
            end
            if (wr_wt_ctrl) begin
                wt_mode_ff <= wbyte[WT_MODE_BIT];
                wt_run_ff <= wbyte[WT_RUN_BIT];
                wt_clk_sel_ff <= tpf_wt_clk_t'(wbyte[2:0]);
            end
            if (wr_wt_hi) wt_hi_ff <= wbyte;
            if (wr_wt_lo) wt_lo_ff <= wbyte;
            if (wr_m1) mask_one_ff <= wbyte;
            if (wr_m2) mask_two_ff <= wbyte;
            if (wr_aux) begin
                ext0_enable_ff <= wbyte[AUX_EXT0_EN_BIT];
                timer_c_run_ff <= wbyte[AUX_TC_RUN_BIT];
            end
        end
    end
    // Capture strobe; a 0 in the capture bit does nothing
    assign ta_soft_cap = wr_ta_ctrl & wbyte[TA_CAP_BIT];
    // Timer A buffers carry no reset
    always_ff @(posedge clk_sys) begin
        if (wr_buf_a) ta_buf_a_ff <= wbyte;
        if (ta_soft_cap) ta_buf_b_ff <= ta_cnt_ff;
        else if (wr_buf_b) ta_buf_b_ff <= wbyte;
    end
    // Free prescaler and pin edge history
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            presc_ff <= RST_PRESC;
            ta_pin_prev_ff <= 1'b0;
            wt_pin_prev_ff <= 1'b0;
            ext3_prev_ff <= 1'b0;
        end else begin
            presc_ff <= presc_ff + 23'h000001;
            ta_pin_prev_ff <= timer_a_pin;
            wt_pin_prev_ff <= wide_timer_pin;
            ext3_prev_ff <= ext3_pin;
        end
    end
    // Timer A count clock select
    always_comb begin
        case (ta_clk_sel_ff)
            2'h0: ta_tick = &presc_ff[TA_EXP0-1:0];
            2'h1: ta_tick = &presc_ff[TA_EXP1-1:0];
            2'h2: ta_tick = &presc_ff[TA_EXP2-1:0];
            default: ta_tick = timer_a_pin & ~ta_pin_prev_ff;
        endcase
    end
    // Wide timer count clock select; window mode gates on the pin
    always_comb begin
        case (wt_clk_sel_ff)
            WT_CK_DIV23: wt_tick = &presc_ff[WT_EXP0-1:0];
            WT_CK_DIV13: wt_tick = &presc_ff[WT_EXP1-1:0];
            WT_CK_DIV8: wt_tick = &presc_ff[WT_EXP2-1:0];
            WT_CK_DIV3: wt_tick = &presc_ff[WT_EXP3-1:0];
            WT_CK_FC: wt_tick = 1'b1;
            WT_CK_EXT: wt_tick = wide_timer_pin & ~wt_pin_prev_ff;
            default: wt_tick = 1'b0;
        endcase
        if (wt_mode_ff && !wide_timer_pin) wt_tick = 1'b0;
    end
    assign tc_tick = &presc_ff[TC_DIV_EXP-1:0];
    assign ta_match = ta_run_ff & ta_tick & ~ta_capmode_ff & (ta_cnt_ff == ta_buf_a_ff);
    assign ta_ovf = ta_run_ff & ta_tick & ta_capmode_ff & (ta_cnt_ff == 8'hff);
    assign wt_match = wt_run_ff & wt_tick & (wt_cnt_ff == {wt_hi_ff, wt_lo_ff});
    assign tc_match = timer_c_run_ff & tc_tick & (tc_cnt_ff == timer_c_data_ff);
    // Timer A counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) ta_cnt_ff <= RST_BYTE;
        else if (!ta_run_ff) ta_cnt_ff <= RST_BYTE;
        else if (ta_match) ta_cnt_ff <= RST_BYTE;
        else if (ta_tick) ta_cnt_ff <= ta_cnt_ff + 8'h01;
    end
    // Wide timer counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) wt_cnt_ff <= 16'h0000;
        else if (!wt_run_ff) wt_cnt_ff <= 16'h0000;
        else if (wt_match) wt_cnt_ff <= 16'h0000;
        else if (wt_tick) wt_cnt_ff <= wt_cnt_ff + 16'h0001;
    end
    // Timer C counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) tc_cnt_ff <= RST_BYTE;
        else if (!timer_c_run_ff) tc_cnt_ff <= RST_BYTE;
        else if (tc_match) tc_cnt_ff <= RST_BYTE;
        else if (tc_tick) tc_cnt_ff <= tc_cnt_ff + 8'h01;
    end
    // Flag set and clear terms; a set always beats a clear
    assign ext3_rise = ext3_pin & ~ext3_prev_ff;
    assign ext3_fall = ~ext3_pin & ext3_prev_ff;
    assign set0 = {2'b00, ext3_fall, ext3_rise, 2'b00, wdt_timeout_evt,
                   ext0_evt & ext0_enable_ff};
    assign set1 = {ext5_evt, wt_match, conv_done_evt, 1'b0, ext3_rise | ext3_fall,
                   tc_match, serial_periph_evt, ta_match | ta_ovf};
    assign set2 = {1'b0, serial_rx_err_evt, rx_full_evt, tx_empty_evt, time_base_evt,
                   ext1_evt, 1'b0, basic_timer_ovf_evt};
    assign clr0 = (wr_f0 ? ~wbyte : 8'h00)
                | {7'h00, wr_aux & ~wbyte[AUX_EXT0_EN_BIT]};
    assign clr1 = wr_f1 ? ~wbyte : 8'h00;
    assign clr2 = (wr_f2 ? ~wbyte : 8'h00) | {1'b0, ~serial_enable, 6'h00};
    // Sticky flag registers; unused positions held at 0
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags_zero_ff <= RST_BYTE;
            flags_one_ff <= RST_BYTE;
            flags_two_ff <= RST_BYTE;
        end else begin
            flags_zero_ff <= ((flags_zero_ff & ~clr0) | set0) & F0_USED;
            flags_one_ff <= ((flags_one_ff & ~clr1) | set1) & F1_USED;
            flags_two_ff <= ((flags_two_ff & ~clr2) | set2) & F2_USED;
        end
    end
    // Read data selection
    always_comb begin
        rd_ok = 1'b1;
        rd_byte = 8'h00;
        case (s_axi_araddr)
            OFS_TIMER_C_DATA: rd_byte = timer_c_data_ff;
            OFS_FLAGS_ZERO: rd_byte = flags_zero_ff;
            OFS_FLAGS_ONE: rd_byte = flags_one_ff & mask_one_ff;
            OFS_FLAGS_TWO: rd_byte = flags_two_ff & mask_two_ff;
            OFS_TA_CTRL: rd_byte = {1'b0, ta_run_ff, ta_clk_sel_ff, ta_capmode_ff, 3'h0};
            OFS_TA_BUF_A: rd_byte = ta_buf_a_ff;
            OFS_TA_BUF_B: rd_byte = ta_buf_b_ff;
            OFS_WT_CTRL: rd_byte = {conversion_low_bits, 1'b0, wt_mode_ff, wt_run_ff,
                                    wt_clk_sel_ff};
            OFS_WT_HIGH: rd_byte = wt_hi_ff;
            OFS_WT_LOW: rd_byte = wt_lo_ff;
            OFS_MASK_ONE: rd_byte = mask_one_ff;
            OFS_MASK_TWO: rd_byte = mask_two_ff;
            OFS_AUX_CTRL: rd_byte = {6'h00, timer_c_run_ff, ext0_enable_ff};
            default: rd_ok = 1'b0;
        endcase
    end
    // Read channel
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_OKAY;
        end else if (ar_fire) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h000000, rd_byte};
            rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (r_fire) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    flags_one_read_a: assert property (
        ar_fire && s_axi_araddr == OFS_FLAGS_ONE
        |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(flags_one_ff & mask_one_ff))
        else $error("flags one read not masked");
    flags_two_read_a: assert property (
        ar_fire && s_axi_araddr == OFS_FLAGS_TWO
        |=> s_axi_rdata[7:0] == $past(flags_two_ff & mask_two_ff))
        else $error("flags two read not masked");
    unused_bits_a: assert property (
        ((flags_zero_ff & ~F0_USED) | (flags_one_ff & ~F1_USED)
         | (flags_two_ff & ~F2_USED)) == 8'h00)
        else $error("unused flag bit set");
    no_write_set_a: assert property (
        $rose(flags_two_ff[3]) |-> $past(time_base_evt))
        else $error("flag rose without event");
    wdt_sticky_a: assert property (
        flags_zero_ff[1] && !(wr_f0 && !wbyte[1]) |=> flags_zero_ff[1])
        else $error("watchdog flag lost");
    ext0_disable_a: assert property (
        wr_aux && !wbyte[AUX_EXT0_EN_BIT] && !ext0_evt |=> !flags_zero_ff[0])
        else $error("ext0 flag kept after disable");
    rx_err_clear_a: assert property (
        !serial_enable && !serial_rx_err_evt |=> !flags_two_ff[6])
        else $error("rx error flag not cleared");
    basic_ovf_set_a: assert property (
        basic_timer_ovf_evt |=> flags_two_ff[0] ##1 (flags_two_ff[0] | $past(wr_f2 & ~wbyte[0])))
        else $error("overflow flag missing");
    ext3_edge_a: assert property (
        ext3_rise |=> flags_zero_ff[4] && flags_one_ff[3])
        else $error("ext3 rise not flagged");
    ta_stop_a: assert property (!ta_run_ff |=> ta_cnt_ff == 8'h00)
        else $error("timer a not cleared");
    wt_stop_a: assert property (!wt_run_ff |=> wt_cnt_ff == 16'h0000)
        else $error("wide timer not cleared");
    tc_stop_a: assert property (!timer_c_run_ff |=> tc_cnt_ff == 8'h00)
        else $error("timer c not cleared");
    ta_match_a: assert property (
        ta_match |=> ta_cnt_ff == 8'h00 && flags_one_ff[0])
        else $error("timer a match lost");
    soft_capture_a: assert property (
        ta_soft_cap |=> ta_buf_b_ff == $past(ta_cnt_ff))
        else $error("soft capture missed");
    write_resp_a: assert property (
        aw_fire && w_fire && !aw_have_ff && !w_have_ff ##1 1'b1 |=> s_axi_bvalid)
        else $error("write response late");
    ta_match_c: cover property (ta_match);
    soft_cap_c: cover property (ta_soft_cap && ta_capmode_ff);
    wt_match_c: cover property (wt_match && wt_mode_ff);
    flags_read_c: cover property (ar_fire && s_axi_araddr == OFS_FLAGS_ONE);
endmodule : tpf_top

/* tpf_pkg.sv */
// Shared constants and types for the timer pair and flag register block
package tpf_pkg;
    // Bus geometry
    localparam int AXI_AW = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Register byte addresses
    localparam logic [7:0] OFS_TIMER_C_DATA = 8'h00;
    localparam logic [7:0] OFS_FLAGS_ZERO = 8'h04;
    localparam logic [7:0] OFS_FLAGS_ONE = 8'h08;
    localparam logic [7:0] OFS_FLAGS_TWO = 8'h0c;
    localparam logic [7:0] OFS_TA_CTRL = 8'h10;
    localparam logic [7:0] OFS_TA_BUF_A = 8'h14;
    localparam logic [7:0] OFS_TA_BUF_B = 8'h18;
    localparam logic [7:0] OFS_WT_CTRL = 8'h1c;
    localparam logic [7:0] OFS_WT_HIGH = 8'h20;
    localparam logic [7:0] OFS_WT_LOW = 8'h24;
    localparam logic [7:0] OFS_MASK_ONE = 8'h28;
    localparam logic [7:0] OFS_MASK_TWO = 8'h2c;
    localparam logic [7:0] OFS_AUX_CTRL = 8'h30;
    // Timer A control fields
    localparam int TA_CAP_BIT = 7;
    localparam int TA_RUN_BIT = 6;
    localparam int TA_CK_LSB = 4;
    localparam int TA_MODE_BIT = 3;
    localparam logic [1:0] TA_CK_EXT = 2'h3;
    // Wide timer control fields
    localparam int WT_CONV_LSB = 6;
    localparam int WT_MODE_BIT = 4;
    localparam int WT_RUN_BIT = 3;
    // Aux control fields
    localparam int AUX_EXT0_EN_BIT = 0;
    localparam int AUX_TC_RUN_BIT = 1;
    // Prescaler tap exponents
    localparam int TA_EXP0 = 12;
    localparam int TA_EXP1 = 10;
    localparam int TA_EXP2 = 7;
    localparam int WT_EXP0 = 23;
    localparam int WT_EXP1 = 13;
    localparam int WT_EXP2 = 8;
    localparam int WT_EXP3 = 3;
    // Implemented flag positions
    localparam logic [7:0] F0_USED = 8'h33;
    localparam logic [7:0] F1_USED = 8'hef;
    localparam logic [7:0] F2_USED = 8'h7d;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [22:0] RST_PRESC = 23'h000000;
    // Wide timer clock sources
    typedef enum logic [2:0] {
        WT_CK_DIV23 = 3'b000,
        WT_CK_DIV13 = 3'b001,
        WT_CK_DIV8 = 3'b010,
        WT_CK_DIV3 = 3'b011,
        WT_CK_FC = 3'b100,
        WT_CK_NONE5 = 3'b101,
        WT_CK_NONE6 = 3'b110,
        WT_CK_EXT = 3'b111
    } tpf_wt_clk_t;
endpackage : tpf_pkg

/* tb.sv */
// Bench for the timer pair and flag registers over AXI4-Lite
`timescale 1ns/100ps
module tb;
    import tpf_pkg::*;
    logic clk_sys = 1'h0, rst_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h1, s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, v, m;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, conversion_low_bits = 2'h0;
    logic [10:0] ev = 11'h000;
    logic ext3_pin = 1'h0, serial_enable = 1'h1, timer_a_pin = 1'h0, wide_timer_pin = 1'h0;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int error_cnt = 0, n_compared = 0;
    tpf_top tpf_top_inst (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext0_evt(ev[0]), .wdt_timeout_evt(ev[1]),
        .ext1_evt(ev[2]), .ext5_evt(ev[3]), .ext3_pin, .conv_done_evt(ev[4]),
        .serial_periph_evt(ev[5]), .serial_rx_err_evt(ev[6]), .rx_full_evt(ev[7]),
        .tx_empty_evt(ev[8]), .time_base_evt(ev[9]), .basic_timer_ovf_evt(ev[10]),
        .serial_enable, .conversion_low_bits, .timer_a_pin, .wide_timer_pin);
    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;
    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    task automatic cmp_r(input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: read exp %h got %h", $time, e, g);
        end
    endtask : cmp_r
    task automatic cmp_b(input logic [1:0] e, input logic [1:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: bresp exp %h got %h", $time, e, g);
        end
    endtask : cmp_b
    // One edge of a bounded wait
    task automatic tick(inout int n);
        @(posedge clk_sys);
        n++;
        if (n > 200) begin
            error_cnt++;
            $display("Error at %0t: wait exp %h got %h", $time, 1'h1, 1'h0);
            results();
        end
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
        int n = 0;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            tick(n);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
        int n = 0;
        rq.push_back({r, 24'h0, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            tick(n);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
    endtask : rd
    task automatic pulse_a(input int k);
        repeat (k) begin
            timer_a_pin <= 1'h1;
            @(posedge clk_sys);
            timer_a_pin <= 1'h0;
            @(posedge clk_sys);
        end
    endtask : pulse_a
    // Oldest note against each response
    always @(posedge clk_sys) begin
        if (s_axi_rvalid && s_axi_rready) cmp_r(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready) cmp_b(bq.pop_front(), s_axi_bresp);
    end
    initial begin
        v = 8'($urandom(45445));
        conversion_low_bits <= 2'($urandom);
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        rd(OFS_FLAGS_ZERO, 8'h00);
        rd(OFS_WT_CTRL, {conversion_low_bits, 6'h00});
        wr(OFS_TIMER_C_DATA, v);
        rd(OFS_TIMER_C_DATA, v);
        wr(8'h34, v, RESP_SLVERR);
        rd(8'h34, 8'h00, RESP_SLVERR);
        $display("Test registers done");
        // All event sources and both pin edges
        wr(OFS_AUX_CTRL, 8'h01);
        ev <= 11'h7ff;
        ext3_pin <= 1'h1;
        @(posedge clk_sys);
        ev <= 11'h000;
        ext3_pin <= 1'h0;
        m = 8'($urandom);
        wr(OFS_MASK_ONE, m);
        rd(OFS_FLAGS_ZERO, 8'h33);
        rd(OFS_FLAGS_ONE, m & 8'haa);
        wr(OFS_FLAGS_ONE, 8'hff);
        rd(OFS_FLAGS_ONE, m & 8'haa);
        wr(OFS_FLAGS_ONE, 8'h00);
        wr(OFS_MASK_ONE, 8'hff);
        m = 8'($urandom);
        wr(OFS_MASK_TWO, m);
        rd(OFS_FLAGS_TWO, m & 8'h7d);
        serial_enable <= 1'h0;
        @(posedge clk_sys);
        serial_enable <= 1'h1;
        wr(OFS_MASK_TWO, 8'hff);
        rd(OFS_FLAGS_TWO, 8'h3d);
        wr(OFS_AUX_CTRL, 8'h00);
        rd(OFS_FLAGS_ZERO, 8'h32);
        $display("Test flags done");
        // Timer A on its pin, capture and match at buffer A
        wr(OFS_TA_BUF_A, 8'h03);
        wr(OFS_TA_CTRL, 8'h70);
        pulse_a(2);
        wr(OFS_TA_CTRL, 8'hf0);
        rd(OFS_TA_CTRL, 8'h70);
        rd(OFS_TA_BUF_B, 8'h02);
        rd(OFS_FLAGS_ONE, 8'h00);
        pulse_a(6);
        rd(OFS_FLAGS_ONE, 8'h01);
        // Capture mode: no match at buffer A, count kept for capture
        wr(OFS_FLAGS_ONE, 8'h00);
        wr(OFS_TA_CTRL, 8'h78);
        pulse_a(4);
        wr(OFS_TA_CTRL, 8'hf8);
        rd(OFS_TA_CTRL, 8'h78);
        rd(OFS_TA_BUF_B, 8'h04);
        rd(OFS_FLAGS_ONE, 8'h00);
        wr(OFS_TA_CTRL, 8'h30);
        wr(OFS_TA_CTRL, 8'hb0);
        rd(OFS_TA_BUF_B, 8'h00);
        // Wide timer: plain clock, idle code, window gate
        wr(OFS_WT_HIGH, 8'h00);
        wr(OFS_WT_LOW, 8'h05);
        wr(OFS_FLAGS_ONE, 8'h00);
        wr(OFS_WT_CTRL, 8'h0c);
        repeat (20) @(posedge clk_sys);
        rd(OFS_FLAGS_ONE, 8'h40);
        wr(OFS_WT_CTRL, 8'h0d);
        wr(OFS_FLAGS_ONE, 8'h00);
        repeat (20) @(posedge clk_sys);
        rd(OFS_FLAGS_ONE, 8'h00);
        wr(OFS_WT_CTRL, 8'h1c);
        repeat (20) @(posedge clk_sys);
        rd(OFS_WT_CTRL, {conversion_low_bits, 6'h1c});
        rd(OFS_FLAGS_ONE, 8'h00);
        wide_timer_pin <= 1'h1;
        repeat (20) @(posedge clk_sys);
        rd(OFS_FLAGS_ONE, 8'h40);
        $display("Test timers done");
        // Timer C match, then reset in mid-run
        wr(OFS_WT_CTRL, 8'h00);
        wr(OFS_TIMER_C_DATA, 8'h04);
        wr(OFS_FLAGS_ONE, 8'h00);
        wr(OFS_AUX_CTRL, 8'h02);
        repeat (80) @(posedge clk_sys);
        rd(OFS_FLAGS_ONE, 8'h04);
        rst_n <= 1'h0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        rd(OFS_TA_BUF_A, 8'h03);
        rd(OFS_FLAGS_ZERO, 8'h00);
        $display("Test reset done");
        results();
    end
endmodule : tb
